// ===== include/ufs_map.svh
`ifndef UFS_MAP_SVH
`define UFS_MAP_SVH

// register byte addresses
`define UFS_ADDR_TRANSFER_MODE   32'h5000_1094
`define UFS_ADDR_QUEUE_ENABLE    32'h5000_1098
`define UFS_ADDR_RX_THRESHOLD    32'h5000_109C
`define UFS_ADDR_QUEUE_CONTROL   32'h5000_10C0
`define UFS_ADDR_EVENT_STATUS    32'h5000_10C4
`define UFS_ADDR_EVENT_MASK      32'h5000_10C8

// queue_control_word field positions
`define UFS_QCW_ENABLE_BIT       0
`define UFS_QCW_RX_RESET_BIT     1
`define UFS_QCW_TX_RESET_BIT     2
`define UFS_QCW_MODE_BIT         3
`define UFS_QCW_TX_TRIG_LSB      4
`define UFS_QCW_RX_TRIG_LSB      6

// event status bit positions
`define UFS_EVT_RX_AVAIL         0
`define UFS_EVT_QUEUE_RESET      1
`define UFS_EVT_TX_EMPTY         2

// reset values
`define UFS_RST_MODE             1'h0
`define UFS_RST_ENABLE           1'h0
`define UFS_RST_RX_TRIG          2'h0
`define UFS_RST_TX_TRIG          2'h0
`define UFS_RST_EVENTS           3'h0
`define UFS_RST_RDATA            16'h0000

// receive trigger codes
`define UFS_TRIG_ONE             2'h0
`define UFS_TRIG_QUARTER         2'h1
`define UFS_TRIG_HALF            2'h2
`define UFS_TRIG_TWO_LESS        2'h3

`endif

// ===== include/ufs_pkg.sv
package ufs_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ufs_bus_req_t;

  typedef struct packed {
    logic        dma_rx_req_n;
    logic        dma_tx_req_n;
  } ufs_dma_t;

  typedef struct packed {
    logic        mode;
    logic        enable;
    logic [1:0]  rx_trig;
    logic [1:0]  tx_trig;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [15:0] rdata;
    logic        rx_fifo_rst;
    logic        tx_fifo_rst;
    logic        rx_avail;
    logic        tx_empty;
    ufs_dma_t    dma;
    logic        irq;
  } ufs_state_t;

endpackage : ufs_pkg

// ===== verilog/ufs_threshold.sv
`timescale 1ns/1ps
`include "ufs_map.svh"

module ufs_threshold #(
  parameter int DEPTH = 16,
  parameter int LW    = 5
) (
  input  wire logic [1:0]    trig,
  input  wire logic          enable,
  output logic      [LW-1:0] level
);

  function automatic logic [LW-1:0] trig_level(input logic [1:0] code);
    logic [LW-1:0] d;
    d = LW'(DEPTH);
    case (code)
      `UFS_TRIG_ONE:     trig_level = LW'(1);
      `UFS_TRIG_QUARTER: trig_level = d >> 2;
      `UFS_TRIG_HALF:    trig_level = d >> 1;
      default:           trig_level = d - LW'(2);
    endcase
  endfunction : trig_level

  // queues off: holding register behaves as one character
  always_comb begin
    if (enable) begin
      level = trig_level(trig);
    end else begin
      level = LW'(1);
    end
  end

endmodule : ufs_threshold

// ===== verilog/ufs_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "ufs_map.svh"

// Summary of operation
// - A one-bit alias register writes only the DMA mode field of the queue control word.
// - The DMA mode field picks signalling mode 0 or 1 for both active-low request outputs.
// - A one-bit alias register writes only the queue enable field of the control word.
// - Enable at 1 puts both transmit and receive queues in use; at 0 both are disabled.
// - Enable going from 1 to 0 resets pointers and counts of both queues.
// - A two-bit alias register writes only the receive trigger field of the control word.
// - Trigger 00 is one character, 01 a quarter, 10 half, 11 two below full.
// - In DMA mode 1 the receive request goes low once the receive queue reaches the trigger.
// - All alias registers read and write, reset to 0, and read 0 in unused upper bits.

module ufs_top #(
  parameter int DEPTH = 16,
  parameter int LW    = 5
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [31:0]   addr,
  input  wire logic [15:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [15:0]   rdata,
  input  wire logic [LW-1:0] rx_level,
  input  wire logic [LW-1:0] tx_level,
  output logic               queue_enable,
  output logic               rx_fifo_rst,
  output logic               tx_fifo_rst,
  output logic               rx_avail,
  output logic               dma_rx_req_n,
  output logic               dma_tx_req_n,
  output logic               irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state and bus request

  ufs_pkg::ufs_state_t   st_ff;
  ufs_pkg::ufs_state_t   nxt_st;
  ufs_pkg::ufs_bus_req_t req;
  logic [LW-1:0]         trig_lvl;

  assign req.addr  = addr;
  assign req.wdata = wdata;
  assign req.wr    = wr;
  assign req.rd    = rd;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input ufs_pkg::ufs_bus_req_t r, input logic [31:0] a);
    hit = (r.addr == a);
  endfunction : hit

  function automatic logic [15:0] qcw_image(input ufs_pkg::ufs_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[`UFS_QCW_ENABLE_BIT] = s.enable;
    w[`UFS_QCW_MODE_BIT] = s.mode;
    w[`UFS_QCW_TX_TRIG_LSB +: 2] = s.tx_trig;
    w[`UFS_QCW_RX_TRIG_LSB +: 2] = s.rx_trig;
    qcw_image = w;
  endfunction : qcw_image

  function automatic logic [15:0] zext3(input logic [2:0] v);
    zext3 = {13'h0000, v};
  endfunction : zext3

  ////////////////////////////////////////////////////////////////////////////////
  // receive trigger level

  ufs_threshold #(
    .DEPTH (DEPTH),
    .LW    (LW)
  ) u_thresh (
    .trig   (st_ff.rx_trig),
    .enable (st_ff.enable),
    .level  (trig_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic        wr_mode;
  logic        wr_enable;
  logic        wr_rxtrig;
  logic        wr_qcw;
  logic        rd_status;
  logic        lvl_hit;
  logic        tx_low;
  logic        drop_en;
  logic [2:0]  evt_set;
  logic [2:0]  evt_clr;
  logic [15:0] rd_word;

  always_comb begin
    nxt_st    = st_ff;
    wr_mode   = req.wr && hit(req, `UFS_ADDR_TRANSFER_MODE);
    wr_enable = req.wr && hit(req, `UFS_ADDR_QUEUE_ENABLE);
    wr_rxtrig = req.wr && hit(req, `UFS_ADDR_RX_THRESHOLD);
    wr_qcw    = req.wr && hit(req, `UFS_ADDR_QUEUE_CONTROL);
    rd_status = req.rd && hit(req, `UFS_ADDR_EVENT_STATUS);
    drop_en   = 1'b0;
    evt_set   = 3'h0;
    evt_clr   = 3'h0;
    rd_word   = 16'h0000;

    // alias writes touch only their own field
    if (wr_mode) begin
      nxt_st.mode = req.wdata[0];
    end
    if (wr_enable) begin
      nxt_st.enable = req.wdata[0];
    end
    if (wr_rxtrig) begin
      nxt_st.rx_trig = req.wdata[1:0];
    end

    // full control word write
    nxt_st.rx_fifo_rst = 1'b0;
    nxt_st.tx_fifo_rst = 1'b0;
    if (wr_qcw) begin
      nxt_st.enable  = req.wdata[`UFS_QCW_ENABLE_BIT];
      nxt_st.mode    = req.wdata[`UFS_QCW_MODE_BIT];
      nxt_st.tx_trig = req.wdata[`UFS_QCW_TX_TRIG_LSB +: 2];
      nxt_st.rx_trig = req.wdata[`UFS_QCW_RX_TRIG_LSB +: 2];
      // self-clearing queue resets
      nxt_st.rx_fifo_rst = req.wdata[`UFS_QCW_RX_RESET_BIT];
      nxt_st.tx_fifo_rst = req.wdata[`UFS_QCW_TX_RESET_BIT];
    end

    // disabling after enabled resets both queue controllers
    drop_en = st_ff.enable && !nxt_st.enable;
    if (drop_en) begin
      nxt_st.rx_fifo_rst = 1'b1;
      nxt_st.tx_fifo_rst = 1'b1;
    end

    // receive level against trigger
    lvl_hit = (rx_level >= trig_lvl);
    tx_low  = (tx_level == LW'(0));
    nxt_st.rx_avail = lvl_hit;
    nxt_st.tx_empty = tx_low;

    // request outputs, active low
    if (st_ff.mode) begin
      // mode 1: rx on trigger, tx while room in queue
      nxt_st.dma.dma_rx_req_n = !lvl_hit;
      nxt_st.dma.dma_tx_req_n = !(tx_level < LW'(DEPTH));
    end else begin
      // mode 0: rx on any character, tx on empty
      nxt_st.dma.dma_rx_req_n = (rx_level == LW'(0));
      nxt_st.dma.dma_tx_req_n = !tx_low;
    end
    // a queue in reset raises no request
    if (nxt_st.rx_fifo_rst) begin
      nxt_st.dma.dma_rx_req_n = 1'b1;
    end
    if (nxt_st.tx_fifo_rst) begin
      nxt_st.dma.dma_tx_req_n = 1'b1;
    end

    // events, set wins over read clear
    evt_set[`UFS_EVT_RX_AVAIL]    = lvl_hit && !st_ff.rx_avail;
    evt_set[`UFS_EVT_QUEUE_RESET] = nxt_st.rx_fifo_rst || nxt_st.tx_fifo_rst;
    evt_set[`UFS_EVT_TX_EMPTY]    = tx_low && !st_ff.tx_empty;
    if (rd_status) begin
      evt_clr = 3'h7;
    end
    nxt_st.status = (st_ff.status & ~evt_clr) | evt_set;

    if (req.wr && hit(req, `UFS_ADDR_EVENT_MASK)) begin
      nxt_st.mask = req.wdata[2:0];
    end

    // read mux, unused bits and unmapped addresses read 0
    if (req.rd) begin
      case (req.addr)
        `UFS_ADDR_TRANSFER_MODE: rd_word = {15'h0000, st_ff.mode};
        `UFS_ADDR_QUEUE_ENABLE:  rd_word = {15'h0000, st_ff.enable};
        `UFS_ADDR_RX_THRESHOLD:  rd_word = {14'h0000, st_ff.rx_trig};
        `UFS_ADDR_QUEUE_CONTROL: rd_word = qcw_image(st_ff);
        `UFS_ADDR_EVENT_STATUS:  rd_word = zext3(st_ff.status);
        `UFS_ADDR_EVENT_MASK:    rd_word = zext3(st_ff.mask);
        default:                 rd_word = 16'h0000;
      endcase
    end
    nxt_st.rdata = rd_word;

    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff.mode              <= `UFS_RST_MODE;
      st_ff.enable            <= `UFS_RST_ENABLE;
      st_ff.rx_trig           <= `UFS_RST_RX_TRIG;
      st_ff.tx_trig           <= `UFS_RST_TX_TRIG;
      st_ff.status            <= `UFS_RST_EVENTS;
      st_ff.mask              <= `UFS_RST_EVENTS;
      st_ff.rdata             <= `UFS_RST_RDATA;
      st_ff.rx_fifo_rst       <= 1'b0;
      st_ff.tx_fifo_rst       <= 1'b0;
      st_ff.rx_avail          <= 1'b0;
      st_ff.tx_empty          <= 1'b1;  // idle queue is empty, no false event
      st_ff.dma.dma_rx_req_n  <= 1'b1;
      st_ff.dma.dma_tx_req_n  <= 1'b1;
      st_ff.irq               <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata        = st_ff.rdata;
  assign queue_enable = st_ff.enable;
  assign rx_fifo_rst  = st_ff.rx_fifo_rst;
  assign tx_fifo_rst  = st_ff.tx_fifo_rst;
  assign rx_avail     = st_ff.rx_avail;
  assign dma_rx_req_n = st_ff.dma.dma_rx_req_n;
  assign dma_tx_req_n = st_ff.dma.dma_tx_req_n;
  assign irq          = st_ff.irq;

endmodule : ufs_top

// ===== verification/ufs_chk.sv
`timescale 1ns/1ps
`include "ufs_map.svh"
module ufs_chk #(
  parameter int DEPTH = 16,
  parameter int LW    = 5
) (
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic [31:0]   addr,
  input wire logic          rd,
  input wire logic [15:0]   rdata,
  input wire logic [LW-1:0] rx_level,
  input wire logic [LW-1:0] tx_level,
  input wire logic          queue_enable,
  input wire logic          rx_fifo_rst,
  input wire logic          tx_fifo_rst,
  input wire logic          rx_avail,
  input wire logic          dma_rx_req_n,
  input wire logic          dma_tx_req_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("rdata not zero outside read reply");
  chk_enable_read: assert property ($past(rd) && $past(addr) == `UFS_ADDR_QUEUE_ENABLE
    |-> rdata == {15'h0000, queue_enable}) else $error("enable alias read wrong");
  chk_upper_zero: assert property ($past(rd) && $past(addr[31:4]) == 28'h5000109
    && $past(addr[3:0]) > 4'h3 |-> rdata[15:2] == 14'h0000) else $error("upper bits set");
  chk_disable_reset: assert property ($fell(queue_enable) |-> rx_fifo_rst && tx_fifo_rst)
    else $error("no queue reset on disable");
  chk_req_quiet: assert property (!(rx_fifo_rst && !dma_rx_req_n)
    && !(tx_fifo_rst && !dma_tx_req_n)) else $error("request during queue reset");
  chk_rx_empty: assert property ($past(rst_n) && $past(rx_level) == 0
    |-> dma_rx_req_n && !rx_avail) else $error("request with empty queue");
  chk_rx_full: assert property ($past(rst_n) && $past(rx_level) >= DEPTH - 2
    && !rx_fifo_rst |-> !dma_rx_req_n && rx_avail) else $error("no request near full");
  chk_tx_req: assert property ($past(rst_n) && !tx_fifo_rst && ($past(tx_level) == 0
    || $past(tx_level) == DEPTH) |-> dma_tx_req_n == ($past(tx_level) == DEPTH))
    else $error("tx request wrong");
endmodule : ufs_chk
////////////////////////////////////////
bind ufs_top ufs_chk #(.DEPTH(DEPTH), .LW(LW)) chk_i (
  .clk          (clk),
  .rst_n        (rst_n),
  .addr         (addr),
  .rd           (rd),
  .rdata        (rdata),
  .rx_level     (rx_level),
  .tx_level     (tx_level),
  .queue_enable (queue_enable),
  .rx_fifo_rst  (rx_fifo_rst),
  .tx_fifo_rst  (tx_fifo_rst),
  .rx_avail     (rx_avail),
  .dma_rx_req_n (dma_rx_req_n),
  .dma_tx_req_n (dma_tx_req_n)
);

// ===== verification/ufs_dma_model.sv
`timescale 1ns/1ps
module ufs_dma_model #(
  parameter int LW = 5
) (
  input  wire logic          clk,
  input  wire logic          load,
  input  wire logic [LW-1:0] fill,
  input  wire logic          drain,
  input  wire logic          dma_rx_req_n,
  output logic      [LW-1:0] rx_level
);
  // controller takes one character a cycle while asked
  always_ff @(posedge clk) begin
    if (load) begin
      rx_level <= fill;
    end else if (drain && !dma_rx_req_n && rx_level != '0) begin
      rx_level <= rx_level - 1'b1;
    end
  end
endmodule : ufs_dma_model

// ===== verification/uart_fifo_shadow_controls_test.sv
`timescale 1ns/1ps
`include "ufs_map.svh"
module uart_fifo_shadow_controls_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        load = 1'b1;
  logic        drain = 1'b0;
  logic [4:0]  fill = 5'h00;
  logic [4:0]  tx_level = 5'h00;
  logic [4:0]  rx_level;
  logic [15:0] rdata;
  logic        queue_enable, rx_fifo_rst, tx_fifo_rst, rx_avail;
  logic        dma_rx_req_n, dma_tx_req_n, irq;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #20 clk = ~clk;
  ufs_top DUT (
    .clk          (clk),
    .rst_n        (rst_n),
    .addr         (addr),
    .wdata        (wdata),
    .wr           (wr),
    .rd           (rd),
    .rdata        (rdata),
    .rx_level     (rx_level),
    .tx_level     (tx_level),
    .queue_enable (queue_enable),
    .rx_fifo_rst  (rx_fifo_rst),
    .tx_fifo_rst  (tx_fifo_rst),
    .rx_avail     (rx_avail),
    .dma_rx_req_n (dma_rx_req_n),
    .dma_tx_req_n (dma_tx_req_n),
    .irq          (irq)
  );
  ufs_dma_model partner (
    .clk          (clk),
    .load         (load),
    .fill         (fill),
    .drain        (drain),
    .dma_rx_req_n (dma_rx_req_n),
    .rx_level     (rx_level)
  );
  ////////////////////////////////////////
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wreg(logic [31:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rclr(logic [31:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask : rclr
  task automatic rreg(logic [31:0] a, logic [15:0] e, string what);
    rclr(a);
    cmp(what, e, rdata);
  endtask : rreg
  task automatic setq(logic [4:0] r, logic [4:0] t);
    @(posedge clk);
    load <= 1'b1;
    fill <= r;
    tx_level <= t;
    @(posedge clk);
    load <= 1'b0;
    step(2);
  endtask : setq
  ////////////////////////////////////////
  task automatic t_regs;
    rreg(`UFS_ADDR_TRANSFER_MODE, 16'h0000, "mode rst");
    rreg(`UFS_ADDR_QUEUE_ENABLE, 16'h0000, "en rst");
    rreg(`UFS_ADDR_RX_THRESHOLD, 16'h0000, "trig rst");
    wreg(`UFS_ADDR_TRANSFER_MODE, 16'hFFFF);
    wreg(`UFS_ADDR_QUEUE_ENABLE, 16'hFFFF);
    wreg(`UFS_ADDR_RX_THRESHOLD, 16'hFFFF);
    rreg(`UFS_ADDR_QUEUE_CONTROL, 16'h00C9, "word");
    rreg(`UFS_ADDR_RX_THRESHOLD, 16'h0003, "trig");
    wreg(`UFS_ADDR_QUEUE_CONTROL, 16'h0041);
    rreg(`UFS_ADDR_TRANSFER_MODE, 16'h0000, "mode alias");
    rreg(`UFS_ADDR_RX_THRESHOLD, 16'h0001, "trig alias");
    rreg(32'h5000_10A8, 16'h0000, "unmapped");
    $display("regs done");
  endtask : t_regs
  task automatic t_disable;
    wreg(`UFS_ADDR_QUEUE_ENABLE, 16'h0000);
    cmp("pulses", 16'h0003, {14'h0, rx_fifo_rst, tx_fifo_rst});
    cmp("enable", 16'h0000, {15'h0, queue_enable});
    wreg(`UFS_ADDR_QUEUE_ENABLE, 16'h0000);
    cmp("no pulse", 16'h0000, {14'h0, rx_fifo_rst, tx_fifo_rst});
    $display("disable done");
  endtask : t_disable
  task automatic t_trig;
    logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
    wreg(`UFS_ADDR_QUEUE_ENABLE, 16'h0001);
    wreg(`UFS_ADDR_TRANSFER_MODE, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wreg(`UFS_ADDR_RX_THRESHOLD, 16'(k));
      setq(lv[k] - 5'h01, 5'h00);
      cmp("below", 16'h0001, {14'h0, rx_avail, dma_rx_req_n});
      setq(lv[k], 5'h00);
      cmp("at", 16'h0002, {14'h0, rx_avail, dma_rx_req_n});
    end
    wreg(`UFS_ADDR_TRANSFER_MODE, 16'h0000);
    setq(5'h01, 5'h00);
    cmp("mode 0", 16'h0000, {14'h0, rx_avail, dma_rx_req_n});
    $display("trig done");
  endtask : t_trig
  task automatic t_drain;
    int i;
    wreg(`UFS_ADDR_TRANSFER_MODE, 16'h0001);
    wreg(`UFS_ADDR_RX_THRESHOLD, 16'h0002);
    setq(5'h0A, 5'h10);
    drain <= 1'b1;
    for (i = 0; i < 40 && dma_rx_req_n !== 1'b1; i++) step(1);
    if (i == 40) begin
      n_fail++;
      results;
    end
    step(2);
    cmp("drained", 16'h0006, {11'h0, rx_level});
    cmp("tx full", 16'h0001, {15'h0, dma_tx_req_n});
    drain <= 1'b0;
    setq(5'h00, 5'h00);
    $display("drain done");
  endtask : t_drain
  task automatic t_flush;
    rclr(`UFS_ADDR_EVENT_STATUS);
    wreg(`UFS_ADDR_QUEUE_CONTROL, 16'h0003);
    cmp("flush", 16'h0002, {14'h0, rx_fifo_rst, tx_fifo_rst});
    rreg(`UFS_ADDR_EVENT_STATUS, 16'h0002, "flush evt");
    rreg(`UFS_ADDR_TRANSFER_MODE, 16'h0000, "mode by word");
    $display("flush done");
  endtask : t_flush
  task automatic t_reset;
    wreg(`UFS_ADDR_TRANSFER_MODE, 16'h0001);
    wreg(`UFS_ADDR_RX_THRESHOLD, 16'h0002);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    cmp("rst outs", 16'h0001, {11'h0, queue_enable, rx_fifo_rst, tx_fifo_rst, irq, dma_rx_req_n});
    rreg(`UFS_ADDR_TRANSFER_MODE, 16'h0000, "mode rerst");
    rreg(`UFS_ADDR_QUEUE_ENABLE, 16'h0000, "en rerst");
    rreg(`UFS_ADDR_RX_THRESHOLD, 16'h0000, "trig rerst");
    $display("reset done");
  endtask : t_reset
  task automatic t_irq;
    wreg(`UFS_ADDR_EVENT_MASK, 16'h0000);
    rclr(`UFS_ADDR_EVENT_STATUS);
    setq(5'h0F, 5'h00);
    cmp("masked", 16'h0000, {15'h0, irq});
    wreg(`UFS_ADDR_EVENT_MASK, 16'h0001);
    step(1);
    cmp("irq", 16'h0001, {15'h0, irq});
    rreg(`UFS_ADDR_EVENT_STATUS, 16'h0001, "status");
    step(2);
    cmp("cleared", 16'h0000, {15'h0, irq});
    $display("irq done");
  endtask : t_irq
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    load <= 1'b0;
    t_regs;
    t_disable;
    t_trig;
    t_drain;
    t_flush;
    t_irq;
    t_reset;
    results;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    results;
  end
endmodule : uart_fifo_shadow_controls_test
